// File: hw/osspc_pkg.sv
// osspc_pkg: constants, field layout and carrier types for output align and status pin control
package osspc_pkg;
    // register addresses carried in the low five bits of a serial word
    localparam logic [4:0] OSSPC_ADDR_FEEDBACK = 5'h0A;
    localparam logic [4:0] OSSPC_ADDR_SYNC_MODE = 5'h0B;
    localparam logic [4:0] OSSPC_ADDR_LOCK_PIN = 5'h0C;
    localparam logic [4:0] OSSPC_ADDR_DELAY_LAST = 5'h05;
    localparam int OSSPC_ADDR_W = 5;
    localparam int OSSPC_WORD_W = 32;

    // sync_and_mode_config fields
    localparam int OSSPC_ALIGN_EN_BIT = 26;
    localparam int OSSPC_EXCL_LSB = 20;
    localparam int OSSPC_GROUPS = 6;
    localparam int OSSPC_SHARED_SEL_LSB = 18;
    localparam int OSSPC_QUALIFY_BIT = 17;
    localparam int OSSPC_POL_BIT = 16;
    localparam int OSSPC_AUTO_BIT = 15;
    localparam int OSSPC_SYNC_TYPE_LSB = 12;
    localparam int OSSPC_XTAL_BIT = 5;

    // lock_pin_and_forced_align_config fields
    localparam int OSSPC_LOCK_SEL_LSB = 27;
    localparam int OSSPC_LOCK_TYPE_LSB = 24;
    localparam int OSSPC_HOLD_L2_BIT = 23;
    localparam int OSSPC_HOLD_L1_BIT = 22;
    localparam int OSSPC_TRACK_BIT = 8;

    // feedback selector field of the feedback register
    localparam int OSSPC_FB_SEL_LSB = 5;
    localparam logic [2:0] OSSPC_FB_EXTERNAL = 3'h6;

    // values after reset: only align enable is set
    localparam logic [31:0] OSSPC_SYNC_MODE_RST = 32'h0400_0000;
    localparam logic [31:0] OSSPC_LOCK_PIN_RST = 32'h0000_0000;
    localparam logic [2:0] OSSPC_FB_SEL_RST = 3'h0;

    // pin io type codes
    localparam logic [2:0] OSSPC_TYPE_OUT = 3'h3;
    localparam logic [2:0] OSSPC_TYPE_OUT_INV = 3'h4;
    localparam logic [2:0] OSSPC_TYPE_OPEN_SRC = 3'h5;
    localparam logic [2:0] OSSPC_TYPE_OPEN_DRN = 3'h6;

    // lock pin selector codes
    localparam logic [4:0] OSSPC_LK_DIV_FIRST = 5'h0B;
    localparam logic [4:0] OSSPC_LK_DIV_LAST = 5'h12;

    // length of an internally generated align pulse
    localparam int OSSPC_PULSE_NS = 1000;
    localparam int OSSPC_CLK_NS = 100;
    localparam int OSSPC_PULSE_CYC = (OSSPC_PULSE_NS + OSSPC_CLK_NS - 1) / OSSPC_CLK_NS;
    localparam logic [3:0] OSSPC_PULSE_CNT = 4'(OSSPC_PULSE_CYC);

    // drive of one status pin
    typedef struct packed {
        logic out;
        logic oe;
    } osspc_pin_t;

    // status levels arriving from the analog side, all asynchronous
    typedef struct packed {
        logic [7:0] divider_clk; // loop n/r divider outputs, full then halved
        logic conv_high;
        logic conv_low;
        logic conv_rail;
        logic conv_locked;
        logic holdover;
        logic third_in_selected;
        logic third_in_los;
        logic loop2_lock;
        logic loop1_lock;
    } osspc_status_t;

    // one-hot align states
    typedef enum logic [1:0] {
        OSSPC_ST_RUN = 2'b01,
        OSSPC_ST_HOLD = 2'b10
    } osspc_state_t;
endpackage : osspc_pkg

// File: hw/osspc_top.sv
// osspc_top: three-wire config port, output group align control and status pin drive
// How it works
// (R1) align enable gates every align event
// (R2) align enable rising fires one align pulse
// (R3) host never uses enable rising to align; the bench aligns once by raising it
// (R4) six exclude bits keep pairs out of align
// (R5) included groups held low, excluded run on
// (R6) delay applies only at align release
// (R7) exclusion never disturbs existing group phase
// (R8) shared pin selector: low, los, selected, readback
// (R9) type 3 drives true, type 4 inverts
// (R10) qualify times hold edges to fed-back clock
// (R11) host keeps group 4/5 powered when qualifying
// (R12) polarity bit sets align pin active level
// (R13) output mode forces input 0, polarity asserts
// (R14) auto mode aligns on latch-enable fall
// (R15) sync pin type: inputs, outputs, open modes
// (R16) crystal amplifier enable bit drives amplifier
// (R17) lock pin selector picks status or dividers
// (R18) host avoids loop-2 r dividers when conflicting
// (R19) lock pin type: outputs only, low reserved
// (R20) hold bits keep align until loop lock
// (R21) host keeps qualify off with hold bits
// (R22) tracking bit enables converter tracking
// (R23) feedback selector picks qualifying clock
`timescale 1ns/100ps
`default_nettype none
module osspc_top (
    // system clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // three-wire serial port, clocked by the host
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_serial_latch_enable,
    input wire logic i_readback_data,
    // shared sync / third input pin
    input wire logic i_sync_pin,
    output logic o_sync_pin,
    output logic o_sync_pin_oe,
    output logic [1:0] o_sync_pin_pull,
    // lock status pin
    output logic o_lock_status_pin,
    output logic o_lock_status_pin_oe,
    // analog status and clocks
    input wire osspc_pkg::osspc_status_t i_status,
    input wire logic [5:0] i_group_clk,
    input wire logic i_ext_feedback_clk,
    // align results to the output groups
    output logic [5:0] o_group_hold,
    output logic [5:0] o_delay_apply,
    output logic o_align_active,
    // analog enables
    output logic o_crystal_amp_enable,
    output logic o_track_enable
);
    // pin io type: drive level and output enable per type code
    function automatic osspc_pkg::osspc_pin_t pin_drive(input logic [2:0] ptype,
                                                        input logic val);
        osspc_pkg::osspc_pin_t p;
        p = '{out: 1'b0, oe: 1'b0};
        case (ptype)
            osspc_pkg::OSSPC_TYPE_OUT: p = '{out: val, oe: 1'b1}; // R9
            osspc_pkg::OSSPC_TYPE_OUT_INV: p = '{out: ~val, oe: 1'b1}; // R9
            osspc_pkg::OSSPC_TYPE_OPEN_SRC: p = '{out: 1'b1, oe: val};
            osspc_pkg::OSSPC_TYPE_OPEN_DRN: p = '{out: 1'b0, oe: ~val};
            default: p = '{out: 1'b0, oe: 1'b0}; // inputs and reserved codes float
        endcase
        return p;
    endfunction : pin_drive

    // ---------------- serial clock domain ----------------
    logic [31:0] ser_shift_reg; // word being shifted in, msb first

    // shifts only while latch enable is low; stands still while it is high
    always_ff @(posedge i_ser_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ser_shift_reg <= 32'h0000_0000;
        end else if (!i_serial_latch_enable) begin
            ser_shift_reg <= {ser_shift_reg[30:0], i_ser_data};
        end
    end

    // ---------------- pin synchronisers ----------------
    localparam int SYNC_W = 26; // feedback clocks, status, latch enable, pin
    logic [SYNC_W-1:0] meta_reg; // first stage, read only by the second
    logic [SYNC_W-1:0] sync_reg; // second stage, safe to use
    logic [SYNC_W-1:0] sync_in; // raw asynchronous inputs

    assign sync_in = {i_ext_feedback_clk, i_group_clk, i_status,
                      i_serial_latch_enable, i_sync_pin};

    // two flops on every asynchronous input
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= sync_in;
            sync_reg <= meta_reg;
        end
    end

    // named views of the synchronised vector
    osspc_pkg::osspc_status_t st;
    logic sync_pin_s;
    logic le_s;
    assign sync_pin_s = sync_reg[0];
    assign le_s = sync_reg[1];
    assign st = sync_reg[18:2];

    // ---------------- word capture ----------------
    logic le_prev_reg; // latch enable one cycle ago
    logic le_rise;
    logic le_fall;
    assign le_rise = le_s & ~le_prev_reg;
    assign le_fall = ~le_s & le_prev_reg;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            le_prev_reg <= 1'b0;
        end else begin
            le_prev_reg <= le_s;
        end
    end

    // the shift word is read only after latch enable has crossed: the host
    // gives no serial clock while latch enable is high, so the word is still
    logic [4:0] wr_addr;
    assign wr_addr = ser_shift_reg[4:0];

    logic [31:0] sync_mode_reg; // sync_and_mode_config
    logic [31:0] lock_pin_reg; // lock_pin_and_forced_align_config
    logic [2:0] fb_sel_reg; // feedback selector

    // register writes on the latch enable rising edge
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_mode_reg <= osspc_pkg::OSSPC_SYNC_MODE_RST;
        end else if (le_rise && wr_addr == osspc_pkg::OSSPC_ADDR_SYNC_MODE) begin
            sync_mode_reg <= {ser_shift_reg[31:5], 5'h00};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lock_pin_reg <= osspc_pkg::OSSPC_LOCK_PIN_RST;
        end else if (le_rise && wr_addr == osspc_pkg::OSSPC_ADDR_LOCK_PIN) begin
            lock_pin_reg <= {ser_shift_reg[31:5], 5'h00};
        end
    end

    // only the feedback selector of that register lives here
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fb_sel_reg <= osspc_pkg::OSSPC_FB_SEL_RST;
        end else if (le_rise && wr_addr == osspc_pkg::OSSPC_ADDR_FEEDBACK) begin
            fb_sel_reg <= ser_shift_reg[osspc_pkg::OSSPC_FB_SEL_LSB +: 3];
        end
    end

    // field views
    logic align_en;
    logic [5:0] group_align_exclude;
    logic [1:0] shared_pin_source_select;
    logic align_qualify_by_output;
    logic align_pin_polarity;
    logic auto_align;
    logic [2:0] sync_pin_type;
    logic [4:0] lock_pin_source_select;
    logic [2:0] lock_pin_io_type;
    logic hold_align_until_loop2_lock;
    logic hold_align_until_loop1_lock;
    assign align_en = sync_mode_reg[osspc_pkg::OSSPC_ALIGN_EN_BIT];
    assign group_align_exclude = sync_mode_reg[osspc_pkg::OSSPC_EXCL_LSB +: 6];
    assign shared_pin_source_select = sync_mode_reg[osspc_pkg::OSSPC_SHARED_SEL_LSB +: 2];
    assign align_qualify_by_output = sync_mode_reg[osspc_pkg::OSSPC_QUALIFY_BIT];
    assign align_pin_polarity = sync_mode_reg[osspc_pkg::OSSPC_POL_BIT];
    assign auto_align = sync_mode_reg[osspc_pkg::OSSPC_AUTO_BIT];
    assign sync_pin_type = sync_mode_reg[osspc_pkg::OSSPC_SYNC_TYPE_LSB +: 3];
    assign lock_pin_source_select = lock_pin_reg[osspc_pkg::OSSPC_LOCK_SEL_LSB +: 5];
    assign lock_pin_io_type = lock_pin_reg[osspc_pkg::OSSPC_LOCK_TYPE_LSB +: 3];
    assign hold_align_until_loop2_lock = lock_pin_reg[osspc_pkg::OSSPC_HOLD_L2_BIT];
    assign hold_align_until_loop1_lock = lock_pin_reg[osspc_pkg::OSSPC_HOLD_L1_BIT];

    // analog enables straight from their bits
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_crystal_amp_enable <= 1'b0;
            o_track_enable <= 1'b0;
        end else begin
            o_crystal_amp_enable <= sync_mode_reg[osspc_pkg::OSSPC_XTAL_BIT]; // R16
            o_track_enable <= lock_pin_reg[osspc_pkg::OSSPC_TRACK_BIT]; // R22
        end
    end

    // ---------------- align event sources ----------------
    logic align_en_prev_reg; // enable one cycle ago, for the rising edge
    logic auto_pend_reg; // delay write seen, waiting for latch enable fall
    logic [3:0] pulse_cnt_reg; // remaining cycles of an internal pulse

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            align_en_prev_reg <= 1'b1;
        end else begin
            align_en_prev_reg <= align_en;
        end
    end

    // a delay register write in auto mode fires at the latch enable fall
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            auto_pend_reg <= 1'b0;
        end else if (le_rise) begin
            auto_pend_reg <= auto_align && wr_addr <= osspc_pkg::OSSPC_ADDR_DELAY_LAST; // R14
        end else if (le_fall) begin
            auto_pend_reg <= 1'b0;
        end
    end

    // internal pulse: enable rising edge, or the auto write firing
    logic pulse_start;
    assign pulse_start = (align_en & ~align_en_prev_reg) // R2
                       | (auto_pend_reg & le_fall); // R14

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pulse_cnt_reg <= 4'h0;
        end else if (pulse_start) begin
            pulse_cnt_reg <= osspc_pkg::OSSPC_PULSE_CNT;
        end else if (pulse_cnt_reg != 4'h0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
        end
    end

    // pin input is ignored while the pin is an output, then polarity decides
    logic pin_is_input;
    logic pin_level;
    logic forced_hold;
    logic align_req;
    assign pin_is_input = sync_pin_type < osspc_pkg::OSSPC_TYPE_OUT; // R15
    assign pin_level = (pin_is_input & sync_pin_s) ^ align_pin_polarity; // R12 R13
    assign forced_hold = (hold_align_until_loop2_lock & ~st.loop2_lock) // R20
                       | (hold_align_until_loop1_lock & ~st.loop1_lock); // R20
    // nothing aligns while the enable is clear, forced holds included
    assign align_req = align_en & (pin_level | forced_hold | (pulse_cnt_reg != 4'h0)); // R1

    // ---------------- qualification ----------------
    logic fb_prev_reg; // selected feedback clock one cycle ago
    logic fb_sel_clk;
    logic fb_edge;
    logic [6:0] fb_bank;
    assign fb_bank = sync_reg[SYNC_W-1:SYNC_W-7];
    // selector codes 0..5 are the group clocks, 6 the external input
    assign fb_sel_clk = (fb_sel_reg <= osspc_pkg::OSSPC_FB_EXTERNAL) ? fb_bank[fb_sel_reg] // R23
                                                                      : 1'b0;
    assign fb_edge = fb_sel_clk & ~fb_prev_reg;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fb_prev_reg <= 1'b0;
        end else begin
            fb_prev_reg <= fb_sel_clk;
        end
    end

    // state changes only on the fed-back clock's edge when qualifying;
    // a stopped feedback clock therefore freezes the hold state
    logic step_ok;
    assign step_ok = ~align_qualify_by_output | fb_edge; // R10

    // ---------------- align state ----------------
    osspc_pkg::osspc_state_t state_reg;
    osspc_pkg::osspc_state_t state_next;
    logic [5:0] held_groups_reg; // groups caught by the current event

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            osspc_pkg::OSSPC_ST_RUN: begin
                if (align_req && step_ok) begin
                    state_next = osspc_pkg::OSSPC_ST_HOLD;
                end
            end
            osspc_pkg::OSSPC_ST_HOLD: begin
                if (!align_req && step_ok) begin
                    state_next = osspc_pkg::OSSPC_ST_RUN;
                end
            end
            default: state_next = osspc_pkg::OSSPC_ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= osspc_pkg::OSSPC_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // the included set is taken at event start; a later exclude write
    // lets a held group go but never re-phases running groups
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            held_groups_reg <= 6'h00;
        end else if (state_next == osspc_pkg::OSSPC_ST_HOLD) begin
            if (state_reg == osspc_pkg::OSSPC_ST_RUN) begin
                held_groups_reg <= ~group_align_exclude; // R4
            end else begin
                held_groups_reg <= held_groups_reg & ~group_align_exclude; // R7
            end
        end else begin
            held_groups_reg <= 6'h00;
        end
    end

    // held groups stay low; excluded groups are never touched
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_group_hold <= 6'h00;
            o_align_active <= 1'b0;
        end else begin
            o_group_hold <= held_groups_reg; // R5
            o_align_active <= state_reg == osspc_pkg::OSSPC_ST_HOLD;
        end
    end

    // new delay values load into held groups only as they are released
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_delay_apply <= 6'h00;
        end else if (state_reg == osspc_pkg::OSSPC_ST_RUN && o_align_active) begin
            // same edge as the hold outputs drop, so apply never leads release
            o_delay_apply <= o_group_hold & ~group_align_exclude; // R6
        end else begin
            o_delay_apply <= 6'h00;
        end
    end

    // ---------------- shared sync / third input pin ----------------
    logic shared_val;
    osspc_pkg::osspc_pin_t shared_drv;
    always_comb begin
        case (shared_pin_source_select)
            2'h0: shared_val = 1'b0; // R8
            2'h1: shared_val = st.third_in_los; // R8
            2'h2: shared_val = st.third_in_selected; // R8
            default: shared_val = i_readback_data; // R8
        endcase
    end
    assign shared_drv = pin_drive(sync_pin_type, shared_val); // R15

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sync_pin <= 1'b0;
            o_sync_pin_oe <= 1'b0;
            o_sync_pin_pull <= 2'h0;
        end else begin
            o_sync_pin <= shared_drv.out;
            o_sync_pin_oe <= shared_drv.oe;
            // bit 0 pull-up, bit 1 pull-down, for input types 1 and 2
            o_sync_pin_pull <= {sync_pin_type == 3'h2, sync_pin_type == 3'h1}; // R15
        end
    end

    // ---------------- lock status pin ----------------
    logic lock_val;
    logic [4:0] div_idx;
    osspc_pkg::osspc_pin_t lock_drv;
    assign div_idx = lock_pin_source_select - osspc_pkg::OSSPC_LK_DIV_FIRST;
    always_comb begin
        case (lock_pin_source_select)
            5'h00: lock_val = 1'b0;
            5'h01: lock_val = st.loop1_lock;
            5'h02: lock_val = st.loop2_lock;
            5'h03: lock_val = st.loop1_lock & st.loop2_lock;
            5'h04: lock_val = st.holdover;
            5'h05: lock_val = st.conv_locked;
            5'h07: lock_val = i_readback_data;
            5'h08: lock_val = st.conv_rail;
            5'h09: lock_val = st.conv_low;
            5'h0A: lock_val = st.conv_high;
            default: begin
                // divider outputs; reserved and unused codes read low
                if (lock_pin_source_select >= osspc_pkg::OSSPC_LK_DIV_FIRST
                    && lock_pin_source_select <= osspc_pkg::OSSPC_LK_DIV_LAST) begin
                    lock_val = st.divider_clk[div_idx[2:0]]; // R17
                end else begin
                    lock_val = 1'b0;
                end
            end
        endcase
    end
    // reserved types 0..2 leave the pin undriven
    assign lock_drv = pin_drive(lock_pin_io_type, lock_val); // R19

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lock_status_pin <= 1'b0;
            o_lock_status_pin_oe <= 1'b0;
        end else begin
            o_lock_status_pin <= lock_drv.out; // R17
            o_lock_status_pin_oe <= lock_drv.oe;
        end
    end
endmodule : osspc_top
`default_nettype wire

// File: tb/osspc_host.sv
// osspc_host: host model writing words over the three-wire port
`timescale 1ns/100ps
`default_nettype none
module osspc_host (
    // serial lines toward the device
    output logic o_ser_clk,
    output logic o_ser_data,
    output logic o_le
);
    // lines idle with the clock low and the latch open
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b1;
        o_le = 1'b0;
    end

    // msb first; the clock stands still between words
    // latch high and low each last 400 ns, above the 300 ns floor
    task automatic send(input logic [31:0] w);
        #3.3;
        for (int b = 31; b >= 0; b--) begin
            o_ser_data = w[b];
            #7.5 o_ser_clk = 1'b1;
            #7.5 o_ser_clk = 1'b0;
        end
        o_ser_data = ~w[0]; // stale data must not look valid
        #10 o_le = 1'b1;
        #400 o_le = 1'b0;
        #400;
    endtask : send
endmodule : osspc_host
`default_nettype wire

// File: tb/osspc_chk.sv
// osspc_chk: port-level assertions for align control and pin drive
`timescale 1ns/100ps
`default_nettype none
module osspc_chk (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // watched outputs
    input wire logic [5:0] o_group_hold,
    input wire logic [5:0] o_delay_apply,
    input wire logic o_align_active,
    input wire logic o_sync_pin_oe,
    input wire logic [1:0] o_sync_pin_pull,
    input wire logic o_lock_status_pin_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    hold_in_align_a: assert property (|o_group_hold |-> o_align_active)
        else $error("group held outside an align");
    release_clears_a: assert property ($fell(o_align_active) |-> o_group_hold == 6'h00)
        else $error("hold left after align end");
    apply_single_a: assert property (|o_delay_apply |=> o_delay_apply == 6'h00)
        else $error("delay apply longer than one cycle");
    apply_held_a: assert property (|o_delay_apply |-> (o_delay_apply & ~$past(o_group_hold)) == 6'h00)
        else $error("delay applied to a group not held");
    apply_at_end_a: assert property (|o_delay_apply |-> !o_align_active && $past(o_align_active))
        else $error("delay applied outside release");
    no_new_hold_a: assert property (o_align_active && $past(o_align_active)
        |-> (o_group_hold & ~$past(o_group_hold)) == 6'h00)
        else $error("group newly held in mid align");
    pull_off_drive_a: assert property (o_sync_pin_oe |-> o_sync_pin_pull == 2'b00)
        else $error("pull active while driving");
    pull_single_a: assert property (o_sync_pin_pull != 2'b11)
        else $error("both pulls on");

    // main scenarios reached
    cover property ($rose(o_align_active));
    cover property (|o_delay_apply);
    cover property (o_sync_pin_oe);
    cover property (o_lock_status_pin_oe);
endmodule : osspc_chk
bind osspc_top osspc_chk i_osspc_chk (.i_clk_sys, .i_rst_b, .o_group_hold, .o_delay_apply,
    .o_align_active, .o_sync_pin_oe, .o_sync_pin_pull, .o_lock_status_pin_oe);
`default_nettype wire

// File: tb/osspc_top_tb.sv
// osspc_top_tb: self-checking bench for align control and status pins
`timescale 1ns/100ps
`default_nettype none
module osspc_top_tb;
    logic i_clk_sys, i_rst_b, i_ser_clk, i_ser_data, i_serial_latch_enable;
    logic i_readback_data, i_sync_pin, i_ext_feedback_clk;
    logic o_sync_pin, o_sync_pin_oe, o_lock_status_pin, o_lock_status_pin_oe;
    logic o_align_active, o_crystal_amp_enable, o_track_enable;
    logic [1:0] o_sync_pin_pull;
    logic [5:0] i_group_clk, o_group_hold, o_delay_apply, ex;
    logic [18:0] v;
    logic [5:0] exp_q[$]; // expected delay-apply patterns
    osspc_pkg::osspc_status_t i_status;
    int error_cnt = 0;
    int checks_done = 0;

    osspc_top i_osspc_top (.*);
    osspc_host i_osspc_host (.o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
        .o_le(i_serial_latch_enable));

    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick

    task automatic wr(input logic [4:0] a, input logic [31:0] w);
        i_osspc_host.send({w[31:5], a});
        tick(2);
    endtask : wr

    // qualify always 0 and group 4/5 never powered down here
    task automatic s0b(input logic en, input logic [5:0] x, input logic [1:0] sl,
        input logic p, input logic au, input logic [2:0] t);
        wr(5'h0B, {5'h0, en, x, sl, 1'b0, p, au, t, 6'h0, 1'b1, 5'h0});
    endtask : s0b

    // bounded wait until every expected release was seen
    task automatic drain;
        for (int n = 0; n < 300 && exp_q.size() > 0; n++) tick(1);
        if (exp_q.size() > 0) begin
            error_cnt++;
            summarize();
        end
    endtask : drain

    // expected {level, enable} of a status pin for its io type
    function automatic logic [5:0] pin(input logic [2:0] t, input logic b);
        case (t)
            3'h3: return {4'h0, b, 1'b1};
            3'h4: return {4'h0, ~b, 1'b1};
            3'h5: return {4'h0, 1'b1, b};
            3'h6: return {4'h0, 1'b0, ~b};
            default: return 6'h00;
        endcase
    endfunction : pin

    // watcher: each release pulse takes the oldest note
    initial forever begin
        tick(1);
        if (|o_delay_apply) chk("apply", exp_q.size() > 0 ? exp_q.pop_front() : 6'h00, o_delay_apply);
    end

    initial begin
        i_rst_b = 1'b0;
        i_readback_data = 1'b0;
        i_sync_pin = 1'b0;
        i_ext_feedback_clk = 1'b0;
        i_group_clk = 6'h00;
        i_status = '0;
        void'($urandom(34));
        tick(4);
        i_rst_b = 1'b1;
        tick(3);
        chk("xtal", 6'h00, {5'h0, o_crystal_amp_enable});
        for (int t = 0; t < 7; t++) begin
            for (int s = 0; s < 4; s++) begin
                i_status = 17'($urandom);
                i_readback_data = 1'($urandom);
                s0b(1'b1, 6'h00, s[1:0], 1'b0, 1'b0, t[2:0]);
                v[3:0] = {i_readback_data, i_status.third_in_selected, i_status.third_in_los, 1'b0};
                if (t < 3) chk("pull", {4'h0, t[1:0]}, {3'h0, o_sync_pin_oe, o_sync_pin_pull});
                else chk("sync_pin", pin(t[2:0], v[s]), {4'h0, o_sync_pin, o_sync_pin_oe});
            end
        end
        chk("xtal", 6'h01, {5'h0, o_crystal_amp_enable});
        // code 4 selects holdover; codes 11 to 18 are the eight divider outputs, so the sweep ends at 18
        for (int t = 3; t < 7; t++) begin
            for (int c = 0; c < 19; c++) begin
                i_status = 17'($urandom);
                i_readback_data = 1'($urandom);
                wr(5'h0C, {c[4:0], t[2:0], 24'h0});
                v = {i_status.divider_clk, i_status.conv_high, i_status.conv_low,
                    i_status.conv_rail, i_readback_data, 1'b0, i_status.conv_locked,
                    i_status.holdover, i_status.loop1_lock & i_status.loop2_lock,
                    i_status.loop2_lock, i_status.loop1_lock, 1'b0};
                chk("lock_pin", pin(t[2:0], v[c]), {4'h0, o_lock_status_pin, o_lock_status_pin_oe});
            end
        end
        wr(5'h0C, 32'h0000_0100);
        chk("track", 6'h01, {5'h0, o_track_enable});
        ex = 6'($urandom) & 6'h3E;
        s0b(1'b1, ex, 2'h0, 1'b0, 1'b1, 3'h3);
        exp_q.push_back(~ex);
        wr(5'h03, $urandom);
        chk("hold", ~ex, o_group_hold);
        drain();
        s0b(1'b0, 6'h00, 2'h0, 1'b0, 1'b1, 3'h3);
        wr(5'h01, 32'h0);
        tick(20);
        chk("active", 6'h00, {5'h0, o_align_active});
        exp_q.push_back(6'h3F);
        s0b(1'b1, 6'h00, 2'h0, 1'b0, 1'b0, 3'h3);
        drain();
        i_sync_pin = 1'b1;
        s0b(1'b1, 6'h00, 2'h0, 1'b1, 1'b0, 3'h3);
        chk("active", 6'h01, {5'h0, o_align_active});
        exp_q.push_back(6'h3F);
        s0b(1'b1, 6'h00, 2'h0, 1'b0, 1'b0, 3'h3);
        drain();
        s0b(1'b1, 6'h00, 2'h0, 1'b1, 1'b0, 3'h0);
        chk("active", 6'h00, {5'h0, o_align_active});
        exp_q.push_back(6'h3F);
        i_sync_pin = 1'b0;
        tick(5);
        chk("active", 6'h01, {5'h0, o_align_active});
        i_sync_pin = 1'b1;
        drain();
        wr(5'h0A, 32'h40);
        wr(5'h0B, 32'h0403_3020);
        chk("active", 6'h00, {5'h0, o_align_active});
        i_group_clk = 6'h04;
        tick(5);
        chk("active", 6'h01, {5'h0, o_align_active});
        exp_q.push_back(6'h3F);
        s0b(1'b1, 6'h00, 2'h0, 1'b0, 1'b0, 3'h3);
        drain();
        for (int k = 0; k < 2; k++) begin
            i_status = 17'h00003;
            wr(5'h0C, 32'h0040_0000 << k);
            i_status[k] = 1'b0;
            tick(5);
            chk("active", 6'h01, {5'h0, o_align_active});
            exp_q.push_back(6'h3F);
            i_status[k] = 1'b1;
            drain();
        end
        summarize();
    end
endmodule : osspc_top_tb
`default_nettype wire
